// ==== pkg/msdp_pkg.sv ====
// Overview of operation
// (R1) Host entry strapping.
// (R2) Divide strap bypass.
// (R3) Interrupt or reset entry.
// (R4) Break after security bytes.
// (R5) Alternate monitor vectors.
// (R6) Watchdog off under high voltage.
// (R7) NRZ, one rate, 28.8k max.
// (R8) Echo bytes, then results.
// (R9) Break: release, then echo.
// (R10) Read returns addressed byte.
// (R11) Indexed read returns two.
// (R12) Stack pointer, high first.
// (R13) Run returns from interrupt.
// (R14) Indexed commands step on.
// (R15) First variant: 4800 or 9600.
// (R16) PLL multiplier scales rate.
// (R17) Second variant follows clock.
// (R18) Check security bytes.
// (R19) Match unlocks until power-on.
// (R20) Mismatch locks flash.
// (R21) Failed check loops resets.
// (R22) Wired-OR link, low only.
// (R23) Start, LSB-first byte, stop.
// (R24) Writes have own opcodes.
package msdp_pkg;
   // Monitor command opcodes.
   localparam logic [7:0] OP_READ = 8'h4A;
   localparam logic [7:0] OP_WRITE = 8'h49;
   localparam logic [7:0] OP_INDEXED_READ_CMD = 8'h1A;
   localparam logic [7:0] OP_INDEXED_WRITE_CMD = 8'h19;
   localparam logic [7:0] OP_STACK_POINTER_READ_CMD = 8'h0C;
   localparam logic [7:0] OP_RUN = 8'h28;
   // Security bytes and vectors.
   localparam logic [15:0] SEC_BASE = 16'hFFF6;
   localparam logic [2:0] SEC_LAST = 3'h7;
   localparam logic [15:0] RST_VEC_USER = 16'hFFFE;
   localparam logic [15:0] RST_VEC_MON = 16'hFEFE;
   localparam logic [15:0] SWI_VEC_USER = 16'hFFFC;
   localparam logic [15:0] SWI_VEC_MON = 16'hFEFC;
   // Bit periods in crystal clock cycles.
   localparam logic [10:0] DIV_V1_SLOW = 11'h400;
   localparam logic [10:0] DIV_V1_FAST = 11'h200;
   localparam logic [10:0] DIV_V2_FAST = 11'h228;
   localparam logic [10:0] DIV_V2_SLOW = 11'h450;
   localparam logic [6:1][10:0] PLL_DIV_TAB = {11'h0AA, 11'h0CC, 11'h100, 11'h155, 11'h200, 11'h400};
   localparam logic [3:0] MUL_MIN = 4'h1;
   localparam logic [3:0] MUL_MAX = 4'h6;
   // Transmit frames, bit 0 first.
   localparam logic [12:0] TX_PAT_BRK = 13'h1C00;
   localparam logic [12:0] TX_PAT_GAP = 13'h1003;
   localparam logic [3:0] TX_LEN_BYTE = 4'hA;
   localparam logic [3:0] TX_LEN_BRK = 4'hB;
   localparam logic [3:0] TX_LEN_GAP = 4'hD;
   localparam logic [3:0] RX_LAST = 4'h9;
   // Register map and fields.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_BAUD = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [9:0] CTRL_RESET = 10'h010;
   localparam int CTRL_WDD = 0;
   localparam int CTRL_MUL_LSB = 4;
   localparam int CTRL_PLL = 8;
   localparam int CTRL_V2 = 9;
   typedef enum logic [1:0] {TX_BYTE = 2'h0, TX_BRK = 2'h1, TX_GAP = 2'h2} msdp_tx_kind_t;
   typedef enum logic [10:0] {
      ST_IDLE = 11'h001, ST_SEC = 11'h002, ST_SECCMP = 11'h004, ST_RDYBRK = 11'h008,
      ST_CMD = 11'h010, ST_ADDRH = 11'h020, ST_ADDRL = 11'h040, ST_WDATA = 11'h080,
      ST_MRD = 11'h100, ST_MWAIT = 11'h200, ST_SEND = 11'h400
   } msdp_state_t;
endpackage

// ==== pkg/msdp_ser_if.sv ====
`timescale 1ns/100ps
// Byte link between command and bit engines.
interface msdp_ser_if;
   import msdp_pkg::*;
   logic [10:0] div;
   logic tx_go;
   msdp_tx_kind_t tx_kind;
   logic [7:0] tx_data;
   logic tx_busy;
   logic rx_valid;
   logic rx_break;
   logic [7:0] rx_data;
   modport ctl (output div, tx_go, tx_kind, tx_data, input tx_busy, rx_valid, rx_break, rx_data);
   modport phy (input div, tx_go, tx_kind, tx_data, output tx_busy, rx_valid, rx_break, rx_data);
endinterface

// ==== test/msdp_host_model.sv ====
`timescale 1ns/100ps
// Host end of the wired-OR link; it only pulls low.
module msdp_host_model (
   // Clock and link.
   input wire logic clk_in,
   input wire logic link_in,
   input wire logic [10:0] div_in,
   // Open-drain drive.
   output logic drive_low_out
);
   initial drive_low_out = 1'b0;
   // One idle bit first so our start edge is heard.
   task automatic send(input logic [7:0] d);
      logic [8:0] f;
      f = {d, 1'b0};
      repeat (div_in) @(posedge clk_in);
      for (int i = 0; i < 9; i++) begin
         drive_low_out <= !f[i];
         repeat (div_in) @(posedge clk_in);
      end
      drive_low_out <= 1'b0;
   endtask
   // Finds a start bit and samples mid-bit.
   task automatic recv(output logic [7:0] d, output logic stop);
      for (int n = 0; n < 9999 && !link_in; n++) @(posedge clk_in);
      for (int n = 0; n < 20000 && link_in; n++) @(posedge clk_in);
      repeat (div_in / 2) @(posedge clk_in);
      for (int i = 0; i < 9; i++) begin
         repeat (div_in) @(posedge clk_in);
         if (i < 8) d[i] = link_in;
         else stop = link_in;
      end
   endtask
endmodule // msdp_host_model

// ==== test/msdp_top_sva.sv ====
`timescale 1ns/100ps
// Port-level checks of the monitor block.
module msdp_top_sva import msdp_pkg::*; (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Watched inputs.
   input wire logic irq_high_voltage_in,
   input wire logic reset_high_voltage_in,
   input wire logic s_axi_bready,
   input wire logic s_axi_rready,
   // Watched outputs.
   input wire logic host_link_pin_out,
   input wire logic monitor_mode_out,
   input wire logic [15:0] reset_vector_out,
   input wire logic [15:0] swi_vector_out,
   input wire logic watchdog_enable_out,
   input wire logic flash_unlocked_out,
   input wire logic run_rti_out,
   input wire logic mem_re_out,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_rvalid
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // A lagging vector would start user code.
   a_mon_vectors: assert property (monitor_mode_out |-> reset_vector_out == RST_VEC_MON &&
      swi_vector_out == SWI_VEC_MON) else $error("monitor vectors wrong");
   a_user_vectors: assert property (!monitor_mode_out |-> reset_vector_out == RST_VEC_USER &&
      swi_vector_out == SWI_VEC_USER) else $error("user vectors wrong");
   a_wdog_off: assert property (monitor_mode_out && (irq_high_voltage_in || reset_high_voltage_in)
      |=> !watchdog_enable_out) else $error("watchdog on under high voltage");
   a_link_low_only: assert property (host_link_pin_out == 1'b0) else $error("link driven high");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid))
      else $error("rvalid dropped early");
   a_rti_pulse: assert property (run_rti_out |=> !run_rti_out) else $error("run pulse too long");
   a_read_pulse: assert property (mem_re_out |=> !mem_re_out) else $error("read strobe too long");
   a_unlock_holds: assert property (flash_unlocked_out |=> flash_unlocked_out)
      else $error("access lost");
endmodule // msdp_top_sva
bind msdp_top msdp_top_sva msdp_top_sva_i (.*);

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
// Bench for the monitor block.
module tb_top;
   import msdp_pkg::*;
   logic clk_in, rst_in, irq_high_voltage_in, reset_high_voltage_in, entry_strap_high_pin_in;
   logic entry_strap_low_pin_in, clock_divide_strap_pin_in, host_link_pin_in, host_link_pin_out;
   logic host_link_pin_oe_out, por_in, swi_in, flash_exec_in, mem_we_out, mem_re_out, monitor_mode_out;
   logic clock_bypass_out, watchdog_enable_out, flash_unlocked_out, illegal_reset_out, run_rti_out;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, host_low, stp;
   logic [15:0] stack_pointer_in, mem_addr_out, reset_vector_out, swi_vector_out;
   logic [7:0] mem_wdata_out, mem_rdata_in, s_axi_awaddr, s_axi_araddr, b, hi;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [23:0] wr_log;
   int failures, comparisons;
   int rti_count = 0;
   // Pull-up wire.
   assign host_link_pin_in = !(host_link_pin_oe_out || host_low);
   msdp_top msdp_top_i (.*);
   msdp_host_model msdp_host_model_i (.clk_in(clk_in), .link_in(host_link_pin_in), .div_in(11'h0AA),
      .drive_low_out(host_low));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = !clk_in;
   end
   function automatic logic [7:0] memf(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   // Memory and pulse log, on the falling edge.
   always @(negedge clk_in) begin
      if (mem_re_out) mem_rdata_in <= memf(mem_addr_out);
      if (mem_we_out) wr_log <= {mem_addr_out, mem_wdata_out};
      if (run_rti_out) rti_count <= rti_count + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      @(posedge clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int n = 0; n < 99; n++) begin
         @(posedge clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge clk_in);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int n = 0; n < 99; n++) begin
         @(posedge clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            {v, r} = {s_axi_rdata, s_axi_rresp};
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic echo(input logic [7:0] v);
      msdp_host_model_i.send(v);
      msdp_host_model_i.recv(b, stp);
      chk(b, v);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Straps held through reset.
   initial begin
      {rst_in, por_in, irq_high_voltage_in, entry_strap_high_pin_in} = 4'hF;
      {reset_high_voltage_in, entry_strap_low_pin_in, clock_divide_strap_pin_in, swi_in} = 4'h0;
      {flash_exec_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mem_rdata_in, s_axi_wstrb} = 60'h00000000000000F;
      seed = xorshift(32'h7E2A20EB);
      stack_pointer_in = seed[15:0];
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      @(posedge clk_in);
      chk({monitor_mode_out, clock_bypass_out, watchdog_enable_out}, 3'h6);
      axw(ADDR_CTRL, 32'h160, rsp);
      chk(rsp, RESP_OKAY);
      axr(ADDR_BAUD, d, rsp);
      chk(d, PLL_DIV_TAB[6]);
      axw(8'h0C, 32'h1, rsp);
      chk(rsp, RESP_SLVERR);
      axr(8'h0C, d, rsp);
      chk({d, rsp}, {32'h0, RESP_SLVERR});
      $display("test registers ends");
      for (int i = 0; i < 8; i++) echo(memf(16'(SEC_BASE + i)));
      msdp_host_model_i.recv(b, stp);
      chk({b, stp}, 9'h000);
      repeat (170) @(posedge clk_in);
      chk(flash_unlocked_out, 1'b1);
      irq_high_voltage_in <= 1'b0;
      $display("test security ends");
      seed = xorshift(seed);
      echo(OP_WRITE);
      echo(seed[31:24]);
      echo(seed[23:16]);
      echo(seed[7:0]);
      chk(wr_log, {seed[31:16], seed[7:0]});
      chk(watchdog_enable_out, 1'b1);
      echo(OP_READ);
      echo(seed[15:8]);
      echo(seed[7:0]);
      msdp_host_model_i.recv(b, stp);
      chk(b, memf(seed[15:0]));
      echo(OP_INDEXED_READ_CMD);
      msdp_host_model_i.recv(b, stp);
      msdp_host_model_i.recv(hi, stp);
      chk({b, hi}, {memf(16'(seed[15:0] + 1)), memf(16'(seed[15:0] + 2))});
      $display("test memory ends");
      echo(OP_STACK_POINTER_READ_CMD);
      msdp_host_model_i.recv(hi, stp);
      msdp_host_model_i.recv(b, stp);
      chk({hi, b}, stack_pointer_in);
      echo(OP_RUN);
      for (int n = 0; n < 999 && rti_count == 0; n++) @(posedge clk_in);
      chk(rti_count, 1);
      swi_in <= 1'b1;
      @(posedge clk_in);
      swi_in <= 1'b0;
      msdp_host_model_i.recv(b, stp);
      chk({b, stp}, 9'h000);
      $display("test run ends");
      give_verdict();
   end
   // About 74000 cycles are needed.
   initial begin
      repeat (95000) @(posedge clk_in);
      failures++;
      give_verdict();
   end
endmodule // tb_top

// ==== verilog/msdp_serial.sv ====
`timescale 1ns/100ps
module msdp_serial import msdp_pkg::*; (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Open-drain link pin.
   input wire logic link_in,
   output logic link_out,
   output logic link_oe_out,
   // Byte side.
   msdp_ser_if.phy ser
);
   logic rx_busy_q, rx_wait_q, link_q;
   logic [3:0] rx_cnt_q;
   logic [10:0] rx_tmr_q, tx_tmr_q;
   logic [8:0] rx_sh_q;
   logic [12:0] tx_sh_q;
   logic [3:0] tx_left_q;
   wire [8:0] rx_sh_n = {link_in, rx_sh_q[8:1]};
   wire rx_start = link_q & ~link_in & ~ser.tx_busy;
   wire [12:0] tx_load = (ser.tx_kind == TX_BRK) ? TX_PAT_BRK :
                         (ser.tx_kind == TX_GAP) ? TX_PAT_GAP : {3'h7, 1'b1, ser.tx_data, 1'b0};
   wire [3:0] tx_len = (ser.tx_kind == TX_BRK) ? TX_LEN_BRK :
                       (ser.tx_kind == TX_GAP) ? TX_LEN_GAP : TX_LEN_BYTE;
   assign ser.tx_busy = (tx_left_q != 4'h0);

   // Receiver samples mid-bit and ignores our own frames.
   always_ff @(posedge clk_in) begin
      link_q <= link_in;
      ser.rx_valid <= 1'b0;
      ser.rx_break <= 1'b0;
      if (rst_in) begin
         rx_busy_q <= 1'b0;
         rx_wait_q <= 1'b0;
         rx_cnt_q <= 4'h0;
         rx_tmr_q <= 11'h000;
         rx_sh_q <= 9'h000;
         ser.rx_data <= 8'h00;
      end else if (!rx_busy_q) begin
         if (rx_wait_q) begin
            rx_wait_q <= ~link_in;
         end else if (rx_start) begin
            rx_busy_q <= 1'b1;
            rx_cnt_q <= 4'h0;
            rx_tmr_q <= {1'b0, ser.div[10:1]};
         end
      end else if (rx_tmr_q != 11'h000) begin
         rx_tmr_q <= rx_tmr_q - 11'h001;
      end else begin
         rx_tmr_q <= ser.div - 11'h001;
         rx_cnt_q <= rx_cnt_q + 4'h1;
         if (rx_cnt_q == 4'h0) begin
            rx_busy_q <= ~link_in; // R23
         end else begin
            rx_sh_q <= rx_sh_n;
         end
         if (rx_cnt_q == RX_LAST) begin
            rx_busy_q <= 1'b0;
            ser.rx_data <= rx_sh_n[7:0];
            ser.rx_valid <= rx_sh_n[8]; // R23
            ser.rx_break <= (rx_sh_n == 9'h000); // R9
            rx_wait_q <= ~rx_sh_n[8];
         end
      end
   end

   // Transmitter only pulls low; a one releases the pin.
   always_ff @(posedge clk_in) begin
      link_out <= 1'b0; // R22
      if (rst_in) begin
         tx_sh_q <= 13'h1FFF;
         tx_left_q <= 4'h0;
         tx_tmr_q <= 11'h000;
         link_oe_out <= 1'b0;
      end else if (tx_left_q == 4'h0) begin
         if (ser.tx_go) begin
            tx_sh_q <= tx_load;
            tx_left_q <= tx_len;
            tx_tmr_q <= ser.div - 11'h001;
            link_oe_out <= ~tx_load[0]; // R22
         end
      end else if (tx_tmr_q == 11'h000) begin
         tx_sh_q <= {1'b1, tx_sh_q[12:1]};
         tx_left_q <= tx_left_q - 4'h1;
         tx_tmr_q <= ser.div - 11'h001;
         link_oe_out <= (tx_left_q != 4'h1) & ~tx_sh_q[1];
      end else begin
         tx_tmr_q <= tx_tmr_q - 11'h001;
      end
   end
endmodule // msdp_serial

// ==== verilog/msdp_top.sv ====
`timescale 1ns/100ps
module msdp_top import msdp_pkg::*; (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Mode pins.
   input wire logic irq_high_voltage_in,
   input wire logic reset_high_voltage_in,
   input wire logic entry_strap_high_pin_in,
   input wire logic entry_strap_low_pin_in,
   input wire logic clock_divide_strap_pin_in,
   // Host link pin.
   input wire logic host_link_pin_in,
   output logic host_link_pin_out,
   output logic host_link_pin_oe_out,
   // Core status.
   input wire logic por_in,
   input wire logic swi_in,
   input wire logic flash_exec_in,
   input wire logic [15:0] stack_pointer_in,
   // Memory port; data before the next edge.
   output logic [15:0] mem_addr_out,
   output logic [7:0] mem_wdata_out,
   output logic mem_we_out,
   output logic mem_re_out,
   input wire logic [7:0] mem_rdata_in,
   // Mode outputs.
   output logic monitor_mode_out,
   output logic clock_bypass_out,
   output logic [15:0] reset_vector_out,
   output logic [15:0] swi_vector_out,
   output logic watchdog_enable_out,
   output logic flash_unlocked_out,
   output logic illegal_reset_out,
   output logic run_rti_out,
   // AXI4-Lite slave.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   msdp_ser_if ser();
   msdp_state_t state_q;
   logic rel_q, por_q, granted_q, failed_q, match_q;
   logic [9:0] ctrl_q;
   logic [2:0] sec_idx_q;
   logic [7:0] opcode_q, byte_q, last_rx_q;
   logic [15:0] addr_q;
   logic left_q;
   logic aw_have_q, w_have_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   // Bit engine on the shared link pin.
   msdp_serial u_serial (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .link_in(host_link_pin_in),
      .link_out(host_link_pin_out),
      .link_oe_out(host_link_pin_oe_out),
      .ser(ser)
   );

   // Entry is judged on the first clock after reset.
   wire release_now = rel_q & ~rst_in;
   wire entry_ok = irq_high_voltage_in & entry_strap_high_pin_in & ~entry_strap_low_pin_in
                   & host_link_pin_in; // R1
   wire [3:0] mul_raw = ctrl_q[CTRL_MUL_LSB +: 4];
   wire [3:0] mul_n = (mul_raw < MUL_MIN) ? MUL_MIN : (mul_raw > MUL_MAX) ? MUL_MAX : mul_raw; // R7
   wire [10:0] div_v1 = ctrl_q[CTRL_PLL] ? PLL_DIV_TAB[mul_n[2:0]] :
                        (clock_bypass_out ? DIV_V1_FAST : DIV_V1_SLOW); // R15 R16
   wire [10:0] div_v2 = clock_bypass_out ? DIV_V2_FAST : DIV_V2_SLOW; // R17
   assign ser.div = ctrl_q[CTRL_V2] ? div_v2 : div_v1;

   // Receive decode.
   wire got_byte = ser.rx_valid;
   wire sec_match = (mem_rdata_in == byte_q);
   wire op_write = (opcode_q == OP_WRITE);
   wire op_indexed_read_cmd = (opcode_q == OP_INDEXED_READ_CMD);
   wire op_stack_pointer_read_cmd = (opcode_q == OP_STACK_POINTER_READ_CMD);
   wire [15:0] addr_next = addr_q + 16'h0001;

   // Mode and security; grants survive all but power-on reset.
   always_ff @(posedge clk_in) begin
      illegal_reset_out <= 1'b0;
      if (rst_in) begin
         rel_q <= 1'b1;
         monitor_mode_out <= 1'b0;
         clock_bypass_out <= 1'b0;
         if (por_in) begin
            granted_q <= 1'b0; // R19
            failed_q <= 1'b0;
         end
      end else begin
         rel_q <= 1'b0;
         if (release_now) begin
            por_q <= por_in;
            monitor_mode_out <= entry_ok; // R3
            clock_bypass_out <= entry_ok & ~clock_divide_strap_pin_in; // R2
            illegal_reset_out <= failed_q & ~por_in; // R21
         end
         if (state_q == ST_SECCMP && sec_idx_q == SEC_LAST) begin
            if (match_q & sec_match | granted_q) begin
               granted_q <= 1'b1; // R19
            end else begin
               failed_q <= 1'b1; // R20
            end
         end
         if (flash_exec_in & monitor_mode_out & ~granted_q) begin
            illegal_reset_out <= 1'b1; // R20
         end
      end
   end

   // Mode outputs use the next mode so none lags it.
   wire mon_next = release_now ? entry_ok : monitor_mode_out; // R5 R6
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         reset_vector_out <= RST_VEC_USER;
         swi_vector_out <= SWI_VEC_USER;
         watchdog_enable_out <= 1'b0;
         flash_unlocked_out <= 1'b0;
      end else begin
         reset_vector_out <= mon_next ? RST_VEC_MON : RST_VEC_USER; // R5
         swi_vector_out <= mon_next ? SWI_VEC_MON : SWI_VEC_USER; // R5
         watchdog_enable_out <= ~(mon_next & (irq_high_voltage_in | reset_high_voltage_in))
                                & ~ctrl_q[CTRL_WDD]; // R6
         flash_unlocked_out <= ~mon_next | granted_q; // R20
      end
   end

   // Command engine; each byte is echoed first,
   // and results wait for the transmitter.
   always_ff @(posedge clk_in) begin
      ser.tx_go <= 1'b0;
      mem_re_out <= 1'b0;
      mem_we_out <= 1'b0;
      run_rti_out <= 1'b0;
      if (got_byte) begin
         ser.tx_go <= 1'b1; // R8
         ser.tx_kind <= TX_BYTE;
         ser.tx_data <= ser.rx_data;
         byte_q <= ser.rx_data;
         last_rx_q <= ser.rx_data;
      end
      if (rst_in) begin
         state_q <= ST_IDLE;
         ser.tx_go <= 1'b0;
         ser.tx_kind <= TX_BYTE;
         ser.tx_data <= 8'h00;
         byte_q <= 8'h00;
         last_rx_q <= 8'h00;
         opcode_q <= 8'h00;
         addr_q <= 16'h0000;
         mem_addr_out <= 16'h0000;
         mem_wdata_out <= 8'h00;
         sec_idx_q <= 3'h0;
         match_q <= 1'b0;
         left_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (release_now & entry_ok) begin
                  state_q <= ST_SEC; // R4
                  sec_idx_q <= 3'h0;
                  match_q <= 1'b1;
               end else if (swi_in & monitor_mode_out) begin
                  state_q <= ST_RDYBRK; // R3
               end
            end
            ST_SEC: begin
               if (got_byte) begin
                  mem_addr_out <= SEC_BASE + {13'h0000, sec_idx_q}; // R18
                  mem_re_out <= 1'b1;
                  state_q <= ST_SECCMP;
               end
            end
            ST_SECCMP: begin
               match_q <= match_q & sec_match; // R18
               sec_idx_q <= sec_idx_q + 3'h1;
               state_q <= (sec_idx_q == SEC_LAST) ? ST_RDYBRK : ST_SEC;
            end
            ST_RDYBRK: begin
               if (!ser.tx_busy && !ser.tx_go) begin
                  ser.tx_go <= 1'b1; // R4
                  ser.tx_kind <= TX_BRK;
                  state_q <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (ser.rx_break) begin
                  ser.tx_go <= 1'b1; // R9
                  ser.tx_kind <= TX_GAP;
               end else if (got_byte) begin
                  opcode_q <= ser.rx_data;
                  case (ser.rx_data)
                     OP_READ, OP_WRITE: state_q <= ST_ADDRH; // R10 R24
                     OP_INDEXED_WRITE_CMD: state_q <= ST_WDATA; // R24
                     OP_INDEXED_READ_CMD: begin
                        left_q <= 1'b1; // R11
                        state_q <= ST_MRD;
                     end
                     OP_STACK_POINTER_READ_CMD: begin
                        byte_q <= stack_pointer_in[15:8]; // R12
                        left_q <= 1'b1;
                        state_q <= ST_SEND;
                     end
                     OP_RUN: begin
                        run_rti_out <= 1'b1; // R13
                        state_q <= ST_IDLE;
                     end
                     default: state_q <= ST_CMD;
                  endcase
               end
            end
            ST_ADDRH: begin
               if (got_byte) begin
                  addr_q[15:8] <= ser.rx_data; // R10
                  state_q <= ST_ADDRL;
               end
            end
            ST_ADDRL: begin
               if (got_byte) begin
                  addr_q[7:0] <= ser.rx_data;
                  left_q <= 1'b0;
                  state_q <= op_write ? ST_WDATA : ST_MRD;
               end
            end
            ST_WDATA: begin
               if (got_byte) begin
                  mem_addr_out <= op_write ? addr_q : addr_next; // R24
                  if (!op_write) begin
                     addr_q <= addr_next; // R14
                  end
                  mem_wdata_out <= ser.rx_data;
                  mem_we_out <= 1'b1;
                  state_q <= ST_CMD;
               end
            end
            ST_MRD: begin
               mem_addr_out <= op_indexed_read_cmd ? addr_next : addr_q;
               if (op_indexed_read_cmd) begin
                  addr_q <= addr_next; // R11 R14
               end
               mem_re_out <= 1'b1;
               state_q <= ST_MWAIT;
            end
            ST_MWAIT: begin
               byte_q <= mem_rdata_in; // R10
               state_q <= ST_SEND;
            end
            ST_SEND: begin
               if (!ser.tx_busy && !ser.tx_go) begin
                  ser.tx_go <= 1'b1; // R8
                  ser.tx_kind <= TX_BYTE;
                  ser.tx_data <= byte_q;
                  left_q <= 1'b0;
                  if (!left_q) begin
                     state_q <= ST_CMD;
                  end else if (op_stack_pointer_read_cmd) begin
                     byte_q <= stack_pointer_in[7:0]; // R12
                  end else begin
                     state_q <= ST_MRD; // R11
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Register bus: address and data in either order, then one response.
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire wr_ctrl = do_write & (aw_addr_q == ADDR_CTRL);
   wire [31:0] status_word = {16'h0000, last_rx_q, 3'h0, ser.tx_busy, clock_bypass_out,
                              failed_q, granted_q, monitor_mode_out};
   wire ar_known = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_STATUS)
                   | (s_axi_araddr == ADDR_BAUD);
   wire [31:0] rd_word = (s_axi_araddr == ADDR_CTRL) ? {22'h0, ctrl_q} :
                         (s_axi_araddr == ADDR_STATUS) ? status_word :
                         (s_axi_araddr == ADDR_BAUD) ? {21'h0, ser.div} : 32'h0;

   // Write channels.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         ctrl_q <= CTRL_RESET;
      end else begin
         s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_have_q & ~s_axi_bvalid;
         s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~w_have_q & ~s_axi_bvalid;
         if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_ctrl & w_strb_q[0]) begin
            ctrl_q[7:0] <= w_data_q[7:0];
         end
         if (wr_ctrl & w_strb_q[1]) begin
            ctrl_q[9:8] <= w_data_q[9:8];
         end
      end
   end

   // Read channel; unmapped offsets give zero and an error.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= ar_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // msdp_top
